// ===== logic/scfg_pkg.sv
// ============================================================
// shared constants for the strap configuration loader
package scfg_pkg;
    // clock of the logic
    localparam int MCLK_PERIOD_NS = 50;
    // strap vector layout, captured in strap_capture_status
    localparam int STRAP_W = 5;
    localparam int STRAP_IF0_BIT = 0;
    localparam int STRAP_IF1_BIT = 1;
    localparam int STRAP_AC0_BIT = 2;
    localparam int STRAP_AC1_BIT = 3;
    localparam int STRAP_TEST_BIT = 4;
    localparam logic [4:0] STRAP_RESET = 5'h00;
    // host interface selection
    localparam logic [1:0] IF_SPI = 2'h3;
    localparam logic [4:0] I2C_ADDR_UPPER = 5'h1b;
    // auto configurations
    localparam logic [1:0] AC_CFG0 = 2'h0;
    localparam logic [1:0] AC_CFG1 = 2'h1;
    localparam logic [1:0] AC_CFG2 = 2'h2;
    localparam logic [1:0] AC_CFG3 = 2'h3;
    // output signal formats
    localparam logic [1:0] FMT_OFF = 2'h0;
    localparam logic [1:0] FMT_CML = 2'h1;
    localparam logic [1:0] FMT_HSTL = 2'h2;
    localparam logic [1:0] FMT_LVCMOS = 2'h3;
    // output frequencies in MHz
    localparam logic [6:0] FREQ_NONE = 7'h00;
    localparam logic [6:0] FREQ_PCIE_MHZ = 7'h64;
    localparam logic [6:0] FREQ_REF_MHZ = 7'h19;
    localparam logic [6:0] XTAL_FREQ_MHZ = 7'h19;
    // reference input select field
    localparam logic [1:0] REF_SEL_XTAL = 2'h1;
    localparam logic [1:0] REF_SEL_OSC = 2'h2;
    localparam logic [1:0] REF_SEL_RESET = REF_SEL_XTAL;
    localparam logic [1:0] DRIVE_RESET = 2'h0;
    // phase resolution: one period of the 600 MHz internal pll clock
    localparam int PLL_CLK_MHZ = 600;
    localparam logic [10:0] PHASE_STEP_PS = 11'h683;
    localparam int N_OUT = 3;
    localparam int PH_W = 8;
    localparam int OFS_W = 16;
    localparam logic [15:0] OFS_RESET = 16'h0000;
endpackage : scfg_pkg

// ===== logic/scfg_out_lane.sv
`timescale 1ns/1ns
// ============================================================
// one output lane: polarity, drive, stop and phase offset
module scfg_out_lane
    import scfg_pkg::*;
#(
    parameter int PHW = PH_W,
    parameter int OW = OFS_W
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic lane_en,
    input wire logic lane_stop,
    input wire logic [1:0] fmt_in,
    input wire logic pll_clk_level,
    input wire logic out_invert,
    input wire logic [1:0] drive_sel,
    input wire logic phase_en,
    input wire logic [PHW-1:0] phase_amount,
    input wire logic adjust_fire,
    input wire logic align_mode,
    output logic driver_data,
    output logic [1:0] driver_drive,
    output logic driver_on,
    output logic [OW-1:0] phase_offset
);
    logic lvl_q, lvl_d;
    logic on_q, on_d;
    logic [1:0] drv_q, drv_d;
    logic [OW-1:0] ofs_q, ofs_d;
    logic [OW-1:0] amt_ext;
    logic active;

    // ============================================================
    // next values
    assign active = lane_en && (fmt_in != FMT_OFF);
    assign amt_ext = OW'($signed(phase_amount));
    always_comb begin
        lvl_d = lvl_q;
        on_d = active;
        drv_d = drive_sel; // R11
        ofs_d = ofs_q;
        // stop freezes the driver level so the pin never sees a runt pulse
        if (!lane_stop) begin
            lvl_d = active & (pll_clk_level ^ out_invert); // R10 R12
        end
        // alignment restarts from the amount, adjustment adds to the last phase
        if (adjust_fire && phase_en) begin
            if (align_mode) begin
                ofs_d = amt_ext; // R13
            end else begin
                ofs_d = OW'(ofs_q + amt_ext); // R13
            end
        end
    end

    // ============================================================
    // registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            lvl_q <= 1'b0;
            on_q <= 1'b0;
            drv_q <= DRIVE_RESET;
            ofs_q <= OFS_RESET;
        end else begin
            lvl_q <= lvl_d;
            on_q <= on_d;
            drv_q <= drv_d;
            ofs_q <= ofs_d;
        end
    end

    assign driver_data = lvl_q;
    assign driver_on = on_q;
    assign driver_drive = drv_q;
    assign phase_offset = ofs_q;
endmodule : scfg_out_lane

// ===== logic/scfg_strap_loader.sv
`timescale 1ns/1ns
// ============================================================
// strap capture, configuration decode and output setup
// Notes on behaviour
// R1: the five straps are sampled once, when the reset pin rises, and drive the configuration.
// R2: after the reset pin rises the interface straps become the spi miso and csn pins.
// R3: the sampled straps are kept in the strap capture status for software to read.
// R4: a sampled test strap of one enters test mode, so the board holds it low.
// R5: interface straps 00, 01, 10 give i2c addresses 1101100..1101110, and 11 gives spi.
// R6: the auto-config straps pick one of four output setups of cml, hstl and lvcmos clocks.
// R7: every auto-config picks the 25 MHz crystal on the two crystal pins as reference.
// R8: reference select 10 turns crystal pin a into a single-ended oscillator input.
// R9: reference select 01 turns on the on-chip crystal driver.
// R10: an output invert bit of one inverts the clock fed to that output driver.
// R11: each output drive field picks one of four drive strengths.
// R12: each output has its own enable, stop and alignment controls.
// R13: phase control uses one global control with a per-output phase amount.
// R14: one phase step is one 600 MHz internal pll period, 1.667 ns.
// R15: captured straps and the decoded setup hold until the next reset pin pulse.
module scfg_strap_loader
    import scfg_pkg::*;
#(
    parameter int NO = N_OUT,
    parameter int PHW = PH_W,
    parameter int OW = OFS_W
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic active_low_reset_pin,
    input wire logic test_strap_pin,
    input wire logic [1:0] auto_config_select,
    input wire logic if1_miso_in,
    output logic if1_miso_out,
    output logic if1_miso_oe,
    input wire logic if0_csn_in,
    input wire logic spi_miso_data,
    input wire logic spi_miso_drive,
    output logic spi_csn_n,
    output logic strap_phase,
    output logic config_valid,
    output logic [STRAP_W-1:0] strap_capture_status,
    output logic test_mode,
    output logic host_is_spi,
    output logic [6:0] i2c_address,
    output logic [1:0] auto_config,
    input wire logic ref_sel_wr,
    input wire logic [1:0] ref_sel_wdata,
    output logic [1:0] reference_input_select,
    output logic xtal_driver_en,
    output logic crystal_pin_a_se_en,
    output logic [6:0] ref_freq_mhz,
    input wire logic pll_clk_level,
    input wire logic [NO-1:0] lane_en,
    input wire logic [NO-1:0] lane_stop,
    input wire logic [NO-1:0] output_invert,
    input wire logic [NO-1:0][1:0] drive_sel,
    input wire logic pa_arm,
    input wire logic pa_trigger,
    input wire logic pa_cancel,
    input wire logic pa_align_mode,
    output logic pa_armed,
    input wire logic [NO-1:0] phase_en,
    input wire logic [NO-1:0][PHW-1:0] output_phase_amount,
    output logic [10:0] phase_step_ps,
    output logic [NO-1:0][1:0] out_format,
    output logic [NO-1:0][6:0] out_freq_mhz,
    output logic [NO-1:0] driver_data,
    output logic [NO-1:0][1:0] driver_drive,
    output logic [NO-1:0] driver_on,
    output logic [NO-1:0][OW-1:0] phase_offset
);
    typedef enum logic [1:0] {
        SCFG_HOLD = 2'b01,
        SCFG_RUN = 2'b10
    } scfg_state_t;

    scfg_state_t state_q, state_d;
    // two-stage synchronisers; stage one is read only by stage two
    logic [STRAP_W+1:0] sync1_q, sync2_q;
    logic rst_pin_prev_q;
    logic [STRAP_W-1:0] straps_now;
    logic rst_pin_s;
    logic csn_s;
    logic capture;
    logic [STRAP_W-1:0] status_q, status_d;
    logic [1:0] ref_q, ref_d;
    logic arm_prev_q, trig_prev_q, armed_q, armed_d;
    logic fire;
    logic [1:0] ifsel;
    logic [NO-1:0][1:0] fmt;
    logic [NO-1:0][6:0] freq;

    // ============================================================
    // pin synchronisers
    always_ff @(posedge mclk) begin
        if (rst) begin
            sync1_q <= '1;
            sync2_q <= '1;
            rst_pin_prev_q <= 1'b1;
        end else begin
            sync1_q <= {if0_csn_in, active_low_reset_pin, test_strap_pin,
                        auto_config_select, if1_miso_in, if0_csn_in};
            sync2_q <= sync1_q;
            rst_pin_prev_q <= sync2_q[STRAP_W];
        end
    end
    assign straps_now = sync2_q[STRAP_W-1:0];
    assign rst_pin_s = sync2_q[STRAP_W];
    assign csn_s = sync2_q[STRAP_W+1];
    // a rising reset pin is the only capture moment
    assign capture = (state_q == SCFG_HOLD) && rst_pin_s && !rst_pin_prev_q; // R1

    // ============================================================
    // strap role / normal role sequencer
    always_comb begin
        state_d = state_q;
        status_d = status_q;
        case (state_q)
            SCFG_HOLD: begin
                if (capture) begin
                    status_d = straps_now; // R1 R3
                    state_d = SCFG_RUN;
                end
            end
            SCFG_RUN: begin
                // status is left alone here, only a new capture replaces it
                if (!rst_pin_s) begin
                    state_d = SCFG_HOLD; // R15
                end
            end
            default: begin
                state_d = SCFG_HOLD;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= SCFG_HOLD;
            status_q <= STRAP_RESET;
        end else begin
            state_q <= state_d;
            status_q <= status_d;
        end
    end

    assign strap_phase = (state_q == SCFG_HOLD);
    assign config_valid = (state_q == SCFG_RUN);
    assign strap_capture_status = status_q;

    // ============================================================
    // dual-function pins after release
    // miso only drives in the normal role, so it never fights the strap resistor
    assign if1_miso_oe = config_valid && host_is_spi && spi_miso_drive; // R2
    assign if1_miso_out = spi_miso_data; // R2
    assign spi_csn_n = config_valid ? csn_s : 1'b1; // R2

    // ============================================================
    // interface and auto-config decode
    assign ifsel = {status_q[STRAP_IF1_BIT], status_q[STRAP_IF0_BIT]};
    assign test_mode = status_q[STRAP_TEST_BIT]; // R4
    assign host_is_spi = (ifsel == IF_SPI); // R5
    assign i2c_address = {I2C_ADDR_UPPER, ifsel}; // R5
    assign auto_config = {status_q[STRAP_AC1_BIT], status_q[STRAP_AC0_BIT]};

    // output formats per configuration
    always_comb begin
        fmt = '0;
        freq = '0;
        fmt[0] = FMT_CML; // R6
        freq[0] = FREQ_PCIE_MHZ;
        freq[1] = FREQ_NONE;
        freq[2] = FREQ_NONE;
        case (auto_config)
            AC_CFG0: begin
                fmt[1] = FMT_OFF;
            end
            AC_CFG1: begin
                fmt[1] = FMT_CML; // R6
                freq[1] = FREQ_PCIE_MHZ;
            end
            AC_CFG2: begin
                fmt[1] = FMT_HSTL; // R6
                freq[1] = FREQ_PCIE_MHZ;
            end
            AC_CFG3: begin
                fmt[1] = FMT_CML; // R6
                freq[1] = FREQ_PCIE_MHZ;
                fmt[2] = FMT_LVCMOS;
                freq[2] = FREQ_REF_MHZ;
            end
            default: begin
                fmt[1] = FMT_OFF;
            end
        endcase
    end
    assign out_format = fmt;
    assign out_freq_mhz = freq;

    // ============================================================
    // reference input select and phase arming
    always_comb begin
        ref_d = ref_q;
        armed_d = armed_q;
        if (capture) begin
            ref_d = REF_SEL_XTAL; // R7
        end else if (ref_sel_wr && config_valid) begin
            ref_d = ref_sel_wdata;
        end
        // cancel beats a fresh arm, fire disarms
        if (pa_cancel || fire) begin
            armed_d = 1'b0;
        end else if (pa_arm && !arm_prev_q) begin
            armed_d = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ref_q <= REF_SEL_RESET;
            armed_q <= 1'b0;
            arm_prev_q <= 1'b0;
            trig_prev_q <= 1'b0;
        end else begin
            ref_q <= ref_d;
            armed_q <= armed_d;
            arm_prev_q <= pa_arm;
            trig_prev_q <= pa_trigger;
        end
    end

    assign reference_input_select = ref_q;
    assign xtal_driver_en = (ref_q == REF_SEL_XTAL); // R9
    assign crystal_pin_a_se_en = (ref_q == REF_SEL_OSC); // R8
    assign ref_freq_mhz = XTAL_FREQ_MHZ; // R7
    assign fire = armed_q && pa_trigger && !trig_prev_q; // R13
    assign pa_armed = armed_q;
    // offsets count in whole internal pll periods of this size
    assign phase_step_ps = PHASE_STEP_PS; // R14

    // ============================================================
    // output lanes
    for (genvar i = 0; i < NO; i++) begin : g_lane
        scfg_out_lane #(
            .PHW(PHW),
            .OW(OW)
        ) u_lane (
            .mclk(mclk),
            .rst(rst),
            .lane_en(lane_en[i]),
            .lane_stop(lane_stop[i]),
            .fmt_in(fmt[i]),
            .pll_clk_level(pll_clk_level),
            .out_invert(output_invert[i]),
            .drive_sel(drive_sel[i]),
            .phase_en(phase_en[i]),
            .phase_amount(output_phase_amount[i]),
            .adjust_fire(fire),
            .align_mode(pa_align_mode),
            .driver_data(driver_data[i]),
            .driver_drive(driver_drive[i]),
            .driver_on(driver_on[i]),
            .phase_offset(phase_offset[i])
        );
    end

    // ============================================================
    // assertions
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_capture_straps: assert property (capture |=> status_q == $past(straps_now)) // R1
        else $error("strap status not captured at reset release");
    a_capture_to_run: assert property (capture |=> config_valid && !strap_phase) // R3
        else $error("no normal role after capture");
    a_status_hold: assert property (config_valid && $past(config_valid) |-> $stable(status_q)) // R15
        else $error("strap status changed outside a capture");
    a_miso_quiet: assert property (strap_phase |-> !if1_miso_oe) // R2
        else $error("miso driven during strap role");
    a_test_capture: assert property (capture |=> test_mode == $past(test_strap_pin, 3)) // R4
        else $error("test mode does not follow test strap");
    a_i2c_addr: assert property (config_valid && !host_is_spi |-> i2c_address[6:2] == 5'h1b) // R5
        else $error("wrong i2c address prefix");
    a_spi_select: assert property (capture && straps_now[1:0] == 2'h3 |=> host_is_spi) // R5
        else $error("spi not selected by straps 11");
    a_cfg3_lvcmos: assert property (config_valid && auto_config == 2'h3 |-> fmt[2] == 2'h3) // R6
        else $error("config three lacks lvcmos on output three");
    a_ref_default: assert property (capture |=> reference_input_select == 2'h1) // R7
        else $error("reference not crystal after capture");
    a_osc_select: assert property (config_valid && ref_sel_wr && ref_sel_wdata == 2'h2 // R8
        |=> crystal_pin_a_se_en && !xtal_driver_en)
        else $error("oscillator input not enabled");
    a_xtal_select: assert property (config_valid && ref_sel_wr && ref_sel_wdata == 2'h1 // R9
        |=> xtal_driver_en)
        else $error("crystal driver not enabled");
    a_invert_lane: assert property (lane_en[0] && !lane_stop[0] // R10
        |=> driver_data[0] == $past(pll_clk_level ^ output_invert[0]))
        else $error("lane zero polarity wrong");
    a_fire_once: assert property (fire |=> !pa_armed) // R13
        else $error("still armed after trigger");

    c_spi_capture: cover property (capture ##1 host_is_spi);
    c_cfg3: cover property (config_valid && auto_config == 2'h3);
    c_fire: cover property (fire);
endmodule : scfg_strap_loader

// ===== dv/scfg_board_model.sv
`timescale 1ns/1ns
// ============================================================
// board side: reset source, 1k strap resistors and the spi host chip select
module scfg_board_model (
    input wire logic rst_pin_req,
    input wire logic [4:0] strap_val,
    input wire logic host_csn_en,
    input wire logic csn_host,
    input wire logic miso_out,
    input wire logic miso_oe,
    output logic active_low_reset_pin,
    output logic test_strap_pin,
    output logic [1:0] auto_config_select,
    output logic if1_miso_in,
    output logic if0_csn_in
);
    // reset source pulls the pin low while asked to
    assign active_low_reset_pin = ~rst_pin_req;
    // strap resistors; test stays low unless a scenario asks for test mode
    assign test_strap_pin = strap_val[4];
    assign auto_config_select = strap_val[3:2];
    // device drive wins on miso, otherwise the strap resistor sets the level
    assign if1_miso_in = miso_oe ? miso_out : strap_val[1];
    // the host owns csn once it has taken the bus, before that the resistor does
    assign if0_csn_in = host_csn_en ? csn_host : strap_val[0];
endmodule : scfg_board_model

// ===== dv/tb_top.sv
`timescale 1ns/1ns
// ============================================================
// self-checking bench for the strap configuration loader
module tb_top;
    import scfg_pkg::*;
    logic mclk, rst, rst_pin_req, host_csn_en, csn_host;
    logic [4:0] strap_val;
    logic active_low_reset_pin, test_strap_pin, if1_miso_in, if1_miso_out, if1_miso_oe;
    logic if0_csn_in, spi_miso_data, spi_miso_drive, spi_csn_n, strap_phase, config_valid;
    logic test_mode, host_is_spi, ref_sel_wr, xtal_driver_en, crystal_pin_a_se_en;
    logic pll_clk_level, pa_arm, pa_trigger, pa_cancel, pa_align_mode, pa_armed;
    logic [1:0] auto_config_select, auto_config, ref_sel_wdata, reference_input_select;
    logic [4:0] strap_capture_status;
    logic [6:0] i2c_address, ref_freq_mhz;
    logic [2:0] lane_en, lane_stop, output_invert, phase_en, driver_data, driver_on;
    logic [2:0][1:0] drive_sel, out_format, driver_drive;
    logic [2:0][7:0] output_phase_amount;
    logic [10:0] phase_step_ps;
    logic [2:0][6:0] out_freq_mhz;
    logic [2:0][15:0] phase_offset;
    int miscompares = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [1:0] ac, f1, f2;

    scfg_board_model scfg_board_model_inst (.rst_pin_req, .strap_val, .host_csn_en,
        .csn_host, .miso_out(if1_miso_out), .miso_oe(if1_miso_oe), .active_low_reset_pin,
        .test_strap_pin, .auto_config_select, .if1_miso_in, .if0_csn_in);

    scfg_strap_loader scfg_strap_loader_inst (.mclk, .rst, .active_low_reset_pin,
        .test_strap_pin, .auto_config_select, .if1_miso_in, .if1_miso_out, .if1_miso_oe,
        .if0_csn_in, .spi_miso_data, .spi_miso_drive, .spi_csn_n, .strap_phase, .config_valid,
        .strap_capture_status, .test_mode, .host_is_spi, .i2c_address, .auto_config,
        .ref_sel_wr, .ref_sel_wdata, .reference_input_select, .xtal_driver_en,
        .crystal_pin_a_se_en, .ref_freq_mhz, .pll_clk_level, .lane_en, .lane_stop,
        .output_invert, .drive_sel, .pa_arm, .pa_trigger, .pa_cancel, .pa_align_mode,
        .pa_armed, .phase_en, .output_phase_amount, .phase_step_ps, .out_format,
        .out_freq_mhz, .driver_data, .driver_drive, .driver_on, .phase_offset);

    // 20 MHz clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test

    // wide enough for the three 16-bit phase offsets packed together
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // inputs always move a fixed 5 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #5;
    endtask : step

    // board reset pulse: pin low 4 cycles, then 5 cycles for capture to land
    task automatic pin_reset(input logic [4:0] s);
        host_csn_en = 1'b0;
        strap_val = s;
        rst_pin_req = 1'b1;
        step(4);
        rst_pin_req = 1'b0;
        step(5);
    endtask : pin_reset

    task automatic ref_write(input logic [1:0] v);
        ref_sel_wr = 1'b1;
        ref_sel_wdata = v;
        step(1);
        ref_sel_wr = 1'b0;
        step(1);
    endtask : ref_write

    initial begin
        rst = 1'b1;
        rst_pin_req = 1'b1;
        strap_val = 5'h00;
        host_csn_en = 1'b0;
        csn_host = 1'b1;
        spi_miso_data = 1'b0;
        spi_miso_drive = 1'b0;
        ref_sel_wr = 1'b0;
        ref_sel_wdata = 2'h0;
        pll_clk_level = 1'b0;
        lane_en = 3'h0;
        lane_stop = 3'h0;
        output_invert = 3'h0;
        drive_sel = '0;
        pa_arm = 1'b0;
        pa_trigger = 1'b0;
        pa_cancel = 1'b0;
        pa_align_mode = 1'b0;
        phase_en = 3'h0;
        output_phase_amount = '0;
        step(8);
        rst = 1'b0;
        step(2);
        // waiting for the pin rise: nothing captured, spi select held off
        chk(config_valid, 1'b0);
        chk(strap_phase, 1'b1);
        chk(spi_csn_n, 1'b1);
        chk(phase_step_ps, 11'h0683);
        // every interface and auto-config strap combination
        for (int i = 0; i < 16; i++) begin
            pin_reset(5'(i));
            ac = 2'(i >> 2);
            f1 = (ac == AC_CFG0) ? FMT_OFF : ((ac == AC_CFG2) ? FMT_HSTL : FMT_CML);
            f2 = (ac == AC_CFG3) ? FMT_LVCMOS : FMT_OFF;
            chk(strap_capture_status, 5'(i));
            chk({config_valid, strap_phase, test_mode}, 3'h4);
            chk(host_is_spi, (i % 4) == 3);
            if ((i % 4) != 3) chk(i2c_address, {5'h1b, 2'(i)});
            chk(auto_config, ac);
            chk(out_format, {f2, f1, FMT_CML});
            chk(out_freq_mhz, {(ac == AC_CFG3) ? 7'h19 : 7'h00,
                (ac == AC_CFG0) ? 7'h00 : 7'h64, 7'h64});
            chk({reference_input_select, xtal_driver_en, ref_freq_mhz}, {3'h3, 7'h19});
        end
        // after capture the interface straps act as spi select and miso
        host_csn_en = 1'b1;
        csn_host = 1'b0;
        spi_miso_drive = 1'b1;
        spi_miso_data = 1'b1;
        step(4);
        chk(spi_csn_n, 1'b0);
        chk({if1_miso_oe, if1_miso_out}, 2'h3);
        spi_miso_data = 1'b0;
        strap_val = 5'h10;
        step(4);
        chk(if1_miso_out, 1'b0);
        // strap pins moving later leave the captured setup alone
        chk(strap_capture_status, 5'h0f);
        chk(test_mode, 1'b0);
        spi_miso_drive = 1'b0;
        // reference select writes
        ref_write(REF_SEL_OSC);
        chk({crystal_pin_a_se_en, xtal_driver_en}, 2'h2);
        ref_write(REF_SEL_XTAL);
        chk({crystal_pin_a_se_en, xtal_driver_en}, 2'h1);
        // a write while the pin is low is refused, status survives the low
        host_csn_en = 1'b0;
        rst_pin_req = 1'b1;
        step(4);
        ref_write(REF_SEL_OSC);
        chk(reference_input_select, REF_SEL_XTAL);
        chk({config_valid, strap_capture_status}, 6'h0f);
        step(1);
        rst_pin_req = 1'b0;
        step(5);
        chk(test_mode, 1'b1);
        pin_reset(5'h0f);
        // lanes: invert, stop and enable per output
        lane_en = 3'h7;
        output_invert = 3'h2;
        pll_clk_level = 1'b1;
        step(2);
        chk(driver_data, 3'h5);
        chk(driver_on, 3'h7);
        lane_stop = 3'h1;
        pll_clk_level = 1'b0;
        step(2);
        chk(driver_data, 3'h3);
        lane_en = 3'h3;
        step(2);
        chk(driver_on, 3'h3);
        chk(driver_data[2], 1'b0);
        for (int d = 0; d < 4; d++) begin
            drive_sel = {2'(d), 2'(d + 1), 2'(d + 2)};
            step(2);
            chk(driver_drive, {2'(d), 2'(d + 1), 2'(d + 2)});
        end
        // phase: align loads the amount on enabled lanes only
        phase_en = 3'h5;
        output_phase_amount = {8'h09, 8'h07, 8'h05};
        pa_align_mode = 1'b1;
        pa_arm = 1'b1;
        step(1);
        chk(pa_armed, 1'b1);
        pa_trigger = 1'b1;
        step(2);
        chk(phase_offset, {16'h0009, 16'h0000, 16'h0005});
        chk(pa_armed, 1'b0);
        // trigger without arming does nothing
        pa_arm = 1'b0;
        pa_trigger = 1'b0;
        pa_align_mode = 1'b0;
        step(1);
        pa_trigger = 1'b1;
        step(2);
        chk(phase_offset, {16'h0009, 16'h0000, 16'h0005});
        // cancel throws away an armed adjustment
        pa_trigger = 1'b0;
        pa_arm = 1'b1;
        step(1);
        pa_cancel = 1'b1;
        step(1);
        pa_cancel = 1'b0;
        pa_trigger = 1'b1;
        step(2);
        chk(phase_offset, {16'h0009, 16'h0000, 16'h0005});
        // re-arm, then adjust adds the amount to the present offset
        pa_arm = 1'b0;
        pa_trigger = 1'b0;
        step(1);
        pa_arm = 1'b1;
        step(1);
        pa_trigger = 1'b1;
        step(2);
        chk(phase_offset, {16'h0012, 16'h0000, 16'h000a});
        stop_test();
    end
endmodule : tb_top
